/* design/cam_capture_pkg.sv */
package cam_capture_pkg;
    // ****************************************
    // Register map (byte offsets, 32-bit words)
    // ****************************************
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] CFG_OFS = 4'h0;
    localparam logic [ADDR_W-1:0] STAT_OFS = 4'h4;
    localparam logic [ADDR_W-1:0] FCNT_OFS = 4'h8;
    localparam logic [ADDR_W-1:0] LCNT_OFS = 4'hc;
    localparam logic [31:0] CFG_RST = 32'h0000_0000;
    // Config fields
    localparam int CFG_MODE_LSB = 0;
    localparam int CFG_VS_FALL = 2;
    localparam int CFG_HS_LOW = 3;
    localparam int CFG_PCLK_POL = 4;
    localparam int CFG_EN = 5;
    // Status fields
    localparam int ST_IN_FRAME = 0;
    localparam int ST_IN_LINE = 1;
    localparam int ST_OVERFLOW = 2;
    localparam int ST_VBLANK = 3;
    // ****************************************
    // Timing modes and embedded codes
    // ****************************************
    localparam logic [1:0] MODE_EMBEDDED = 2'h0;
    localparam logic [1:0] MODE_GATED = 2'h1;
    localparam logic [1:0] MODE_NONGATED = 2'h2;
    localparam logic [7:0] CODE_FF = 8'hff;
    localparam logic [7:0] CODE_00 = 8'h00;
    localparam int XY_V = 5;
    localparam int XY_H = 4;
    localparam int CODE_DELAY = 3;
    typedef enum logic [1:0] {HUNT, GOT_FF, GOT_00, GOT_00_00} code_state_t;
    // ****************************************
    // Pixel clock range and sampling budget
    // ****************************************
    localparam int PCLK_MIN_KHZ = 10;
    localparam int PCLK_MAX_KHZ = 133000;
    localparam int REF_CLK_KHZ = 125000;
    // Each pixel clock phase must last this many ref_clk cycles to be seen
    localparam int PCLK_MIN_PHASE_CYC = 2;
    localparam int PCLK_MAX_SAMPLED_KHZ = REF_CLK_KHZ / (2 * PCLK_MIN_PHASE_CYC);
endpackage

/* design/camera_sensor_capture_port.sv */
// The address-and-strobe port and the address map were left to the implementer.
module camera_sensor_capture_port
#(
    parameter int DATA_W = 8
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic pixel_clock_in,
    input wire logic frame_sync_in,
    input wire logic line_sync_in,
    input wire logic [DATA_W-1:0] pixel_data_in,
    input wire logic [cam_capture_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic pix_valid,
    input wire logic pix_ready,
    output logic [DATA_W-1:0] pix_data,
    output logic pix_frame_start,
    output logic frame_sync_int,
    output logic line_sync_int
);
    import cam_capture_pkg::*;
    // ****************************************
    // Configuration register
    // ****************************************
    logic [31:0] sensor_config_reg_q;
    logic [1:0] mode;
    logic vs_fall;
    logic hs_low;
    logic pixel_clock_polarity;
    logic enable;
    logic emb;
    logic gated;
    logic nongated;
    assign mode = sensor_config_reg_q[CFG_MODE_LSB +: 2];
    assign vs_fall = sensor_config_reg_q[CFG_VS_FALL];
    assign hs_low = sensor_config_reg_q[CFG_HS_LOW];
    assign pixel_clock_polarity = sensor_config_reg_q[CFG_PCLK_POL];
    assign enable = sensor_config_reg_q[CFG_EN];
    assign emb = (mode == MODE_EMBEDDED);
    assign gated = (mode == MODE_GATED);
    assign nongated = (mode == MODE_NONGATED);
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sensor_config_reg_q <= CFG_RST;
        end else if (clk_en && reg_wr && reg_addr == CFG_OFS) begin
            sensor_config_reg_q <= {26'h0, reg_wdata[5:0]};
        end
    end

    // ****************************************
    // Pin synchronisers
    // ****************************************
    // Pixel clock is oversampled; it must stay below PCLK_MAX_SAMPLED_KHZ
    // here, a rate limit of this sampling scheme, not of the sensor.
    logic pclk_s1_q, pclk_s2_q, pclk_s3_q;
    logic vs_s1_q, vs_s2_q, vs_s3_q;
    logic hs_s1_q, hs_s2_q;
    logic [DATA_W-1:0] dat_s1_q, dat_s2_q;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pclk_s1_q <= 1'b0;
            pclk_s2_q <= 1'b0;
            pclk_s3_q <= 1'b0;
            vs_s1_q <= 1'b0;
            vs_s2_q <= 1'b0;
            vs_s3_q <= 1'b0;
            hs_s1_q <= 1'b0;
            hs_s2_q <= 1'b0;
            dat_s1_q <= '0;
            dat_s2_q <= '0;
        end else if (clk_en) begin
            pclk_s1_q <= pixel_clock_in;
            pclk_s2_q <= pclk_s1_q;
            pclk_s3_q <= pclk_s2_q;
            vs_s1_q <= frame_sync_in;
            vs_s2_q <= vs_s1_q;
            vs_s3_q <= vs_s2_q;
            hs_s1_q <= line_sync_in;
            hs_s2_q <= hs_s1_q;
            dat_s1_q <= pixel_data_in;
            dat_s2_q <= dat_s1_q;
        end
    end

    logic pclk_edge;
    logic vs_edge;
    logic hs_act;
    logic [7:0] byte_in;
    // Data is synchronised beside the clock, so dat_s2_q is the word
    // present at the detected edge.
    assign pclk_edge = pixel_clock_polarity ? (pclk_s3_q && !pclk_s2_q)
                                            : (!pclk_s3_q && pclk_s2_q);
    assign vs_edge = vs_fall ? (vs_s3_q && !vs_s2_q) : (!vs_s3_q && vs_s2_q);
    assign hs_act = hs_s2_q ^ hs_low;
    assign byte_in = dat_s2_q[DATA_W-1 -: 8];
    // ****************************************
    // Embedded timing code decoder
    // ****************************************
    code_state_t code_q;
    logic code_hit;
    logic emb_edge;
    logic emb_line_q;
    logic emb_vblank_q;
    logic [DATA_W-1:0] hist_q [CODE_DELAY];
    logic [CODE_DELAY-1:0] tag_q;
    logic sav_frame;
    assign emb_edge = emb && enable && pclk_edge;
    assign code_hit = emb_edge && (code_q == GOT_00_00);
    assign sav_frame = code_hit && !byte_in[XY_H] && !byte_in[XY_V] && emb_vblank_q;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            code_q <= HUNT;
        end else if (clk_en && emb_edge) begin
            case (code_q)
                HUNT: code_q <= (byte_in == CODE_FF) ? GOT_FF : HUNT;
                GOT_FF: code_q <= (byte_in == CODE_00) ? GOT_00 :
                                  ((byte_in == CODE_FF) ? GOT_FF : HUNT);
                GOT_00: code_q <= (byte_in == CODE_00) ? GOT_00_00 :
                                  ((byte_in == CODE_FF) ? GOT_FF : HUNT);
                GOT_00_00: code_q <= HUNT;
                default: code_q <= HUNT;
            endcase
        end
    end
    // SAV outside vertical blanking opens a line, EAV closes it; V tracks vertical blanking
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            emb_line_q <= 1'b0;
            emb_vblank_q <= 1'b1;
        end else if (clk_en && code_hit) begin
            emb_line_q <= !byte_in[XY_H] && !byte_in[XY_V];
            emb_vblank_q <= byte_in[XY_V];
        end
    end
    // Three-word delay so the code preamble can be withdrawn once the
    // fourth word proves it was a code; costs three pixels of latency.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tag_q <= '0;
            for (int i = 0; i < CODE_DELAY; i++) begin
                hist_q[i] <= '0;
            end
        end else if (clk_en && emb_edge) begin
            hist_q[0] <= dat_s2_q;
            for (int i = 1; i < CODE_DELAY; i++) begin
                hist_q[i] <= hist_q[i-1];
            end
            tag_q <= code_hit ? '0 : {tag_q[CODE_DELAY-2:0], emb_line_q};
        end
    end

    // ****************************************
    // Capture selection for all modes
    // ****************************************
    logic ext_frame;
    logic push;
    logic [DATA_W-1:0] push_data;
    logic frame_pend_q;
    logic in_ready;
    assign ext_frame = !emb && enable && vs_edge;
    always_comb begin
        push = 1'b0;
        push_data = dat_s2_q;
        if (enable) begin
            case (mode)
                MODE_EMBEDDED: begin
                    push = emb_edge && !code_hit && tag_q[CODE_DELAY-1];
                    push_data = hist_q[CODE_DELAY-1];
                end
                MODE_GATED: push = pclk_edge && hs_act;
                MODE_NONGATED: push = pclk_edge;
                default: push = 1'b0;
            endcase
        end
    end
    // First word after a frame start carries the frame-start mark
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_pend_q <= 1'b0;
        end else if (clk_en) begin
            if (ext_frame || sav_frame) begin
                frame_pend_q <= 1'b1;
            end else if (push && in_ready) begin
                frame_pend_q <= 1'b0;
            end
        end
    end

    // ****************************************
    // Regenerated syncs and counters
    // ****************************************
    logic line_next;
    logic in_frame_q;
    logic overflow_q;
    logic [31:0] frame_cnt_q;
    logic [31:0] line_cnt_q;
    always_comb begin
        case (mode)
            MODE_EMBEDDED: line_next = emb_line_q;
            MODE_GATED: line_next = hs_act;
            default: line_next = 1'b0;
        endcase
        line_next = line_next && enable;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_sync_int <= 1'b0;
            line_sync_int <= 1'b0;
            in_frame_q <= 1'b0;
        end else if (clk_en) begin
            frame_sync_int <= ext_frame || sav_frame;
            line_sync_int <= line_next;
            if (ext_frame || sav_frame) begin
                in_frame_q <= 1'b1;
            end else if (!enable || (emb && code_hit && byte_in[XY_V])) begin
                in_frame_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_cnt_q <= '0;
            line_cnt_q <= '0;
        end else if (clk_en) begin
            if (ext_frame || sav_frame) begin
                frame_cnt_q <= frame_cnt_q + 32'h1;
                line_cnt_q <= '0;
            end else if (line_next && !line_sync_int) begin
                line_cnt_q <= line_cnt_q + 32'h1;
            end
        end
    end
    // Sensor cannot be stalled: a word refused by a full buffer is lost
    // and recorded; a new loss wins over a clear in the same cycle.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            overflow_q <= 1'b0;
        end else if (clk_en) begin
            if (push && !in_ready) begin
                overflow_q <= 1'b1;
            end else if (reg_wr && reg_addr == STAT_OFS && reg_wdata[ST_OVERFLOW]) begin
                overflow_q <= 1'b0;
            end
        end
    end

    // ****************************************
    // Register read port
    // ****************************************
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else if (clk_en) begin
            reg_rdata <= '0;
            if (reg_rd) begin
                case (reg_addr)
                    CFG_OFS: reg_rdata <= sensor_config_reg_q;
                    STAT_OFS: reg_rdata <= {28'h0, emb_vblank_q, overflow_q,
                                            line_sync_int, in_frame_q};
                    FCNT_OFS: reg_rdata <= frame_cnt_q;
                    LCNT_OFS: reg_rdata <= line_cnt_q;
                    default: reg_rdata <= '0;
                endcase
            end
        end
    end

    // ****************************************
    // Input FIFO
    // ****************************************
    two_entry_buffer #(
        .W(DATA_W + 1)
    ) u_buf (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .in_valid(push),
        .in_ready(in_ready),
        .in_data({frame_pend_q || ext_frame || sav_frame, push_data}),
        .out_valid(pix_valid),
        .out_ready(pix_ready),
        .out_data({pix_frame_start, pix_data})
    );

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    sequence s_line_idle;
        (gated && !hs_act)[*2];
    endsequence
    sequence s_eav;
        clk_en && code_hit && byte_in[XY_H];
    endsequence
    property p_gated_needs_line;
        (gated && push) |-> hs_act;
    endproperty
    a_gated_needs_line: assert property (p_gated_needs_line)
        else $error("gated capture outside line sync");
    property p_line_stop;
        s_line_idle |-> !push;
    endproperty
    a_line_stop: assert property (p_line_stop)
        else $error("capture continued after line sync dropped");
    property p_nongated_all;
        (nongated && enable && pclk_edge) |-> push;
    endproperty
    a_nongated_all: assert property (p_nongated_all)
        else $error("non-gated pixel edge not written");
    property p_nongated_no_line;
        (clk_en && nongated) |=> !line_sync_int;
    endproperty
    a_nongated_no_line: assert property (p_nongated_no_line)
        else $error("non-gated mode followed line sync");
    property p_frame_edge;
        (clk_en && !emb && enable && vs_edge) |=> frame_sync_int ##1 !frame_sync_int [*1];
    endproperty
    a_frame_edge: assert property (p_frame_edge)
        else $error("frame sync edge did not start a frame");
    property p_emb_pins_ignored;
        (clk_en && emb && !code_hit) |=> !frame_sync_int;
    endproperty
    a_emb_pins_ignored: assert property (p_emb_pins_ignored)
        else $error("embedded mode reacted to sync pins");
    // A frozen edge flag under a low enable would compare stale history
    property p_ext_edge;
        (clk_en && push && !emb) |-> (pixel_clock_polarity ? $fell(pclk_s2_q) : $rose(pclk_s2_q));
    endproperty
    a_ext_edge: assert property (p_ext_edge)
        else $error("capture on wrong pixel clock edge");
    property p_eav_closes;
        s_eav |=> !emb_line_q ##1 !line_sync_int;
    endproperty
    a_eav_closes: assert property (p_eav_closes)
        else $error("end code did not close the line");
    property p_code_dropped;
        (emb && code_hit) |-> !push;
    endproperty
    a_code_dropped: assert property (p_code_dropped)
        else $error("timing code passed as pixel");
endmodule // camera_sensor_capture_port

/* design/two_entry_buffer.sv */
module two_entry_buffer #(
    parameter int W = 9
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    logic [W-1:0] slot1_q;
    logic [1:0] count_q;
    logic push;
    logic pop;

    assign in_ready = (count_q != 2'h2);
    assign out_valid = (count_q != 2'h0);
    assign push = in_valid && in_ready && clk_en;
    assign pop = out_valid && out_ready && clk_en;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= 2'h0;
        end else if (push && !pop) begin
            count_q <= count_q + 2'h1;
        end else if (pop && !push) begin
            count_q <= count_q - 2'h1;
        end
    end

    // Head word sits in out_data so the output is straight from a flop
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_data <= '0;
            slot1_q <= '0;
        end else begin
            if (pop && count_q == 2'h2) begin
                out_data <= slot1_q;
            end else if (push && (count_q == 2'h0 || (pop && count_q == 2'h1))) begin
                out_data <= in_data;
            end
            if (push && ((count_q == 2'h1 && !pop) || count_q == 2'h2)) begin
                slot1_q <= in_data;
            end
        end
    end
endmodule // two_entry_buffer

/* verif/cam_sensor_model.sv */
module cam_sensor_model (
    output logic pclk,
    output logic vsync,
    output logic hsync,
    output logic [7:0] data
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // Link timing and polarity
    // ****************************************
    // 125 ns pixel period, far inside the sensor range and the sampling budget
    localparam realtime HALF = 62.5;
    logic pol_clk = 1'b0;
    logic pol_vs = 1'b0;
    logic pol_hs = 1'b0;

    initial begin
        pclk = 1'b0;
        vsync = 1'b0;
        hsync = 1'b0;
        data = 8'h5a;
    end

    // Clock parks at its inactive level whenever no word is on the bus
    task set_pol(input logic c, input logic v, input logic h);
        pol_clk = c;
        pol_vs = v;
        pol_hs = h;
        pclk = c;
        vsync = v;
        hsync = h;
    endtask

    // ****************************************
    // Transfers
    // ****************************************
    task pixel(input logic [7:0] d);
        data = d;
        #HALF;
        pclk = ~pol_clk;
        #HALF;
        pclk = pol_clk;
    endtask

    task start_frame;
        #HALF;
        vsync = ~pol_vs;
        #(4 * HALF);
        vsync = pol_vs;
        #(2 * HALF);
    endtask

    task line(input int n, input logic [7:0] base);
        hsync = ~pol_hs;
        #HALF;
        for (int i = 0; i < n; i++) begin
            pixel(base + 8'(i));
        end
        #HALF;
        hsync = pol_hs;
        // A released bus must not keep showing the last word
        data = ~data;
        #(2 * HALF);
    endtask

    task gap(input int n, input logic [7:0] base);
        for (int i = 0; i < n; i++) begin
            pixel(base + 8'(i));
        end
        data = ~data;
    endtask

    task code(input logic [7:0] xy);
        pixel(8'hff);
        pixel(8'h00);
        pixel(8'h00);
        pixel(xy);
    endtask

    task emb_line(input int n, input logic [7:0] base);
        code(8'h80);
        for (int i = 0; i < n; i++) begin
            pixel(base + 8'(i));
        end
        code(8'h90);
    endtask
endmodule // cam_sensor_model

/* verif/camera_sensor_capture_port_test.sv */
module camera_sensor_capture_port_test import cam_capture_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // Signals and instances
    // ****************************************
    logic ref_clk = 1'b0;
    logic rst_n, clk_en, pclk, vsync, hsync, reg_wr, reg_rd, pix_ready;
    logic pix_valid, pix_frame_start, frame_sync_int, line_sync_int;
    logic [7:0] pdata, pix_data;
    logic [ADDR_W-1:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rd;
    int num_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    int fs_count = 0;
    int line_count = 0;
    logic line_seen_q = 1'b0;
    logic [8:0] got_q[$];
    logic [8:0] exp_q[$];

    always #4 ref_clk = ~ref_clk;

    camera_sensor_capture_port #(.DATA_W(8)) camera_sensor_capture_port_i (
        .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .pixel_clock_in(pclk),
        .frame_sync_in(vsync), .line_sync_in(hsync), .pixel_data_in(pdata),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .pix_valid(pix_valid), .pix_ready(pix_ready),
        .pix_data(pix_data), .pix_frame_start(pix_frame_start),
        .frame_sync_int(frame_sync_int), .line_sync_int(line_sync_int));

    cam_sensor_model cam_sensor_model_i (.pclk(pclk), .vsync(vsync), .hsync(hsync),
        .data(pdata));

    // Collects every word popped downstream; hang guard well above the run length
    always @(posedge ref_clk) begin
        cycles++;
        if (pix_valid === 1'b1 && pix_ready === 1'b1) begin
            got_q.push_back({pix_frame_start, pix_data});
        end
        if (frame_sync_int === 1'b1) begin
            fs_count++;
        end
        if (line_sync_int === 1'b1 && !line_seen_q) begin
            line_count++;
        end
        line_seen_q <= (line_sync_int === 1'b1);
        if (cycles == 20000) begin
            num_errors++;
            summarize();
        end
    end

    // ****************************************
    // Tasks
    // ****************************************
    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task reg_write(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task reg_read(input logic [ADDR_W-1:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk);
        d = reg_rdata;
    endtask

    task expect_run(input logic [7:0] base, input int n, input logic fs);
        for (int i = 0; i < n; i++) begin
            exp_q.push_back({fs && i == 0, base + 8'(i)});
        end
    endtask

    // Words still in flight land well inside this margin
    task compare_stream;
        repeat (30) @(posedge ref_clk);
        check(32'(got_q.size()), 32'(exp_q.size()));
        for (int i = 0; i < exp_q.size() && i < got_q.size(); i++) begin
            check({23'h0, got_q[i]}, {23'h0, exp_q[i]});
        end
        got_q.delete();
        exp_q.delete();
    endtask

    task summarize;
        $display("checks=%0d errors=%0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        rst_n = 1'b0;
        clk_en = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        pix_ready = 1'b1;
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        reg_read(CFG_OFS, rd);
        check(rd, CFG_RST);
        reg_read(STAT_OFS, rd);
        check(rd, 32'h0000_0008);
        reg_read(4'h1, rd);
        check(rd, 32'h0000_0000);
        reg_write(4'h2, 32'hffff_ffff);
        reg_write(CFG_OFS, 32'hffff_ffc3);
        reg_read(CFG_OFS, rd);
        check(rd, 32'h0000_0003);
        // Gated: pixels between lines must be dropped
        reg_write(CFG_OFS, 32'h0000_0021);
        cam_sensor_model_i.start_frame();
        cam_sensor_model_i.line(4, 8'h10);
        cam_sensor_model_i.gap(2, 8'h20);
        cam_sensor_model_i.line(3, 8'h30);
        expect_run(8'h10, 4, 1'b1);
        expect_run(8'h30, 3, 1'b0);
        compare_stream();
        check(32'(fs_count), 32'h1);
        check(32'(line_count), 32'h2);
        reg_read(FCNT_OFS, rd);
        check(rd, 32'h0000_0001);
        reg_read(LCNT_OFS, rd);
        check(rd, 32'h0000_0002);
        // Stalled receiver: two words kept, the rest lost and flagged
        @(posedge ref_clk);
        pix_ready <= 1'b0;
        cam_sensor_model_i.start_frame();
        cam_sensor_model_i.line(4, 8'h50);
        reg_read(STAT_OFS, rd);
        check({31'h0, rd[ST_OVERFLOW]}, 32'h1);
        check({31'h0, rd[ST_IN_FRAME]}, 32'h1);
        @(posedge ref_clk);
        pix_ready <= 1'b1;
        expect_run(8'h50, 2, 1'b1);
        compare_stream();
        reg_write(STAT_OFS, 32'h0000_0004);
        reg_read(STAT_OFS, rd);
        check({31'h0, rd[ST_OVERFLOW]}, 32'h0);
        check(32'(fs_count), 32'h2);
        // Inverted polarities; disabled while the pins change level
        reg_write(CFG_OFS, 32'h0000_001d);
        cam_sensor_model_i.set_pol(1'b1, 1'b1, 1'b1);
        reg_write(CFG_OFS, 32'h0000_003d);
        cam_sensor_model_i.start_frame();
        cam_sensor_model_i.gap(1, 8'h3c);
        cam_sensor_model_i.line(3, 8'h38);
        expect_run(8'h38, 3, 1'b1);
        compare_stream();
        check(32'(fs_count), 32'h3);
        reg_read(LCNT_OFS, rd);
        check(rd, 32'h0000_0001);
        // Non-gated: line sync ignored, every edge kept
        reg_write(CFG_OFS, 32'h0000_0002);
        cam_sensor_model_i.set_pol(1'b0, 1'b0, 1'b0);
        reg_write(CFG_OFS, 32'h0000_0022);
        cam_sensor_model_i.start_frame();
        cam_sensor_model_i.gap(3, 8'h20);
        cam_sensor_model_i.line(2, 8'h24);
        expect_run(8'h20, 3, 1'b1);
        expect_run(8'h24, 2, 1'b0);
        compare_stream();
        check(32'(fs_count), 32'h4);
        // Mode 3 captures nothing
        reg_write(CFG_OFS, 32'h0000_0023);
        cam_sensor_model_i.line(3, 8'h70);
        compare_stream();
        // Embedded codes; sync pins toggle and must be ignored
        reg_write(CFG_OFS, 32'h0000_0020);
        cam_sensor_model_i.code(8'hb0);
        cam_sensor_model_i.gap(2, 8'h12);
        cam_sensor_model_i.code(8'ha0);
        cam_sensor_model_i.start_frame();
        cam_sensor_model_i.line(2, 8'h14);
        cam_sensor_model_i.emb_line(3, 8'h41);
        cam_sensor_model_i.gap(2, 8'h18);
        cam_sensor_model_i.emb_line(2, 8'h61);
        cam_sensor_model_i.gap(4, 8'h1a);
        expect_run(8'h41, 3, 1'b1);
        expect_run(8'h61, 2, 1'b0);
        compare_stream();
        check(32'(fs_count), 32'h5);
        check(32'(line_count), 32'h6);
        summarize();
    end
endmodule // camera_sensor_capture_port_test
